// [dv/asc_host.sv]
// Host model: classic Wishbone master for the control bank
`default_nettype none
module asc_host (
  // Clock
  input  wire logic        ref_clk,
  // Master side of the bus
  output logic             cyc,
  output logic             stb,
  output logic             we,
  output logic [3:0]       sel,
  output logic [7:0]       adr,
  output logic [31:0]      dw,
  input  wire logic [31:0] dr,
  input  wire logic        ack
);
  timeunit 1ns;
  timeprecision 1ps;
  // Bus idle from time zero
  initial begin
    cyc = 1'b0;
    stb = 1'b0;
    we = 1'b0;
    sel = 4'h0;
    adr = 8'h00;
    dw = 32'h0;
  end
  // Request held until ack is sampled; the wait is bounded so a dead slave cannot hang us
  task automatic xfer(input logic w, input logic [7:0] a, input logic [7:0] d,
                      output logic [7:0] q, output logic ok);
    int n;
    @(posedge ref_clk);
    cyc <= 1'b1;
    stb <= 1'b1;
    we <= w;
    sel <= 4'h1;
    adr <= a;
    dw <= {24'h0, d};
    n = 0;
    do begin
      @(posedge ref_clk);
      n++;
    end while (ack !== 1'b1 && n < 16);
    ok = (ack === 1'b1);
    q = dr[7:0];
    cyc <= 1'b0;
    stb <= 1'b0;
  endtask : xfer
endmodule : asc_host
`default_nettype wire

// [dv/asc_regs_chk.sv]
// Port-level assertions for the system control bank
`default_nettype none
module asc_regs_chk #(
  parameter int unsigned NUM_CH = 6
) (
  // Clock and reset
  input wire logic                ref_clk,
  input wire logic                rst_n,
  // Bus
  input wire logic                wb_cyc_i,
  input wire logic                wb_stb_i,
  input wire logic                wb_we_i,
  input wire logic [3:0]          wb_sel_i,
  input wire logic [7:0]          wb_adr_i,
  input wire logic [31:0]         wb_dat_i,
  input wire logic                wb_ack_o,
  // Decoded controls
  input wire logic                deemph_44k_r,
  input wire logic                deemph_48k_r,
  input wire asc_pkg::asc_frame_t frame_kind_r,
  input wire logic [4:0]          word_len_r,
  input wire logic [NUM_CH-1:0]   channel_run_r,
  input wire logic                outputs_valid_flag_r,
  input wire logic                speaker_mute_r,
  input wire logic                headphone_pwm_outputs_en_r,
  input wire logic                hp_mode_r,
  input wire logic                line_out_mode_r
);
  // Write taken on this edge; ack low keeps a held strobe from counting twice
  logic       wr_take;
  logic [1:0] wr_deemph;
  assign wr_take   = wb_cyc_i & wb_stb_i & wb_we_i & wb_sel_i[0] & ~wb_ack_o;
  assign wr_deemph = wb_dat_i[1:0];

  default clocking cb @(posedge ref_clk);
  endclocking
  default disable iff (!rst_n);

  chk_ack_due: assert property (wb_cyc_i && wb_stb_i && !wb_ack_o |=> wb_ack_o)
    else $error("request not acked next cycle");
  chk_shut_hard: assert property (
    wr_take && wb_adr_i == 8'h14 && wb_dat_i[6] |-> ##2 channel_run_r == '0 ##1 !outputs_valid_flag_r)
    else $error("shutdown write left channels running");
  chk_valid_run: assert property (outputs_valid_flag_r |-> $past(&channel_run_r))
    else $error("valid flag without all channels running");
  chk_deemph_one: assert property (!(deemph_44k_r && deemph_48k_r))
    else $error("both de-emphasis rates selected");
  chk_deemph_code: assert property (
    wr_take && wb_adr_i == 8'h0c
    |-> ##2 deemph_44k_r == ($past(wr_deemph, 2) == 2'h2) && deemph_48k_r == ($past(wr_deemph, 2) == 2'h3))
    else $error("de-emphasis code not decoded");
  chk_fmt_decode: assert property (
    wr_take && wb_adr_i == 8'h10 && wb_dat_i[7:0] == 8'h03
    |-> ##2 frame_kind_r == asc_pkg::ASC_FRAME_I2S && word_len_r == asc_pkg::WL_16)
    else $error("format code not decoded");
  chk_fmt_reset: assert property (
    $rose(rst_n) |-> frame_kind_r == asc_pkg::ASC_FRAME_I2S && word_len_r == asc_pkg::WL_24)
    else $error("format not at default after reset");
  chk_line_out: assert property (line_out_mode_r |-> !hp_mode_r && headphone_pwm_outputs_en_r)
    else $error("line-out mode inconsistent");
  chk_hp_mute: assert property (hp_mode_r |-> speaker_mute_r && headphone_pwm_outputs_en_r)
    else $error("headphone mode without speaker mute");
  chk_mute_cause: assert property (speaker_mute_r |-> hp_mode_r)
    else $error("speakers muted outside headphone mode");

  cov_valid: cover property ($rose(outputs_valid_flag_r));
  cov_hp: cover property ($rose(hp_mode_r));
  cov_line: cover property ($rose(line_out_mode_r));
endmodule : asc_regs_chk

bind asc_regs asc_regs_chk #(.NUM_CH(NUM_CH)) u_chk (
  .ref_clk, .rst_n, .wb_cyc_i, .wb_stb_i, .wb_we_i, .wb_sel_i, .wb_adr_i, .wb_dat_i, .wb_ack_o,
  .deemph_44k_r, .deemph_48k_r, .frame_kind_r, .word_len_r, .channel_run_r, .outputs_valid_flag_r,
  .speaker_mute_r, .headphone_pwm_outputs_en_r, .hp_mode_r, .line_out_mode_r);
`default_nettype wire

// [dv/testbench.sv]
// Self-checking bench for the system control bank
`default_nettype none
module testbench;
  timeunit 1ns;
  timeprecision 1ps;
  logic ref_clk, rst_n, hp_pin, cyc, stb, we, ack, hpm;
  logic dc, hu, ad, ss, d44, d48, s32, fres, valid, mute, hpen, hp, line, hpvol;
  logic [3:0] sel;
  logic [7:0] adr;
  logic [31:0] dw, dr;
  logic [5:0] grp, run;
  logic [4:0] len;
  asc_pkg::asc_frame_t frame;
  int fail_count = 0;
  int total_checks = 0;
  // Format codes and expected {reserved, 32x clock, framing, word length}; 09 reserved keeps last
  logic [7:0] fc [14] = '{8'h00, 8'h01, 8'h02, 8'h03, 8'h04, 8'h05, 8'h06, 8'h07,
                          8'h08, 8'h0a, 8'h13, 8'h16, 8'h09, 8'h05};
  logic [8:0] fx [14] = '{9'h010, 9'h014, 9'h018, 9'h030, 9'h034, 9'h038, 9'h050, 9'h054,
                          9'h058, 9'h012, 9'h0b0, 9'h0d0, 9'h1d0, 9'h038};

  asc_regs #(.NUM_CH(6)) DUT (
    .ref_clk, .rst_n, .wb_cyc_i(cyc), .wb_stb_i(stb), .wb_we_i(we), .wb_adr_i(adr), .wb_sel_i(sel),
    .wb_dat_i(dw), .wb_dat_o(dr), .wb_ack_o(ack), .headphone_select_pin(hp_pin), .shutdown_group(grp),
    .dc_block_en_r(dc), .hard_unmute_r(hu), .clk_autodetect_en_r(ad), .soft_start_en_r(ss),
    .deemph_44k_r(d44), .deemph_48k_r(d48), .frame_kind_r(frame), .word_len_r(len), .sclk_32fs_r(s32),
    .fmt_reserved_r(fres), .channel_run_r(run), .outputs_valid_flag_r(valid), .speaker_mute_r(mute),
    .headphone_pwm_outputs_en_r(hpen), .hp_mode_r(hp), .line_out_mode_r(line), .hp_vol_from_hp_reg_r(hpvol));
  asc_host host (.ref_clk, .cyc, .stb, .we, .sel, .adr, .dw, .dr, .ack);

  // 100 MHz clock
  initial begin
    ref_clk = 1'b0;
    forever #5 ref_clk = ~ref_clk;
  end

  task automatic conclude();
    $display("checks %0d mismatches %0d", total_checks, fail_count);
    if (fail_count == 0 && total_checks > 0) begin
      $display("== PASSED ==");
    end else begin
      $display("== FAILED ==");
    end
    $finish;
  endtask : conclude
  task automatic cmp(input string nm, input logic [31:0] e, input logic [31:0] g);
    total_checks++;
    if (g !== e) begin
      fail_count++;
      $display("unexpected %s expected %h seen %h", nm, e, g);
    end
  endtask : cmp
  // A lost ack ends the run at once
  task automatic acc(input logic w, input logic [7:0] a, input logic [7:0] d, output logic [7:0] q);
    logic ok;
    host.xfer(w, a, d, q, ok);
    if (ok !== 1'b1) begin
      fail_count++;
      conclude();
    end
  endtask : acc
  // Outputs land one edge after the write, the valid flag one later
  task automatic wr(input logic [7:0] a, input logic [7:0] d);
    logic [7:0] q;
    acc(1'b1, a, d, q);
    repeat (2) @(negedge ref_clk);
  endtask : wr
  task automatic rd(input logic [7:0] a, input logic [7:0] e);
    logic [7:0] q;
    acc(1'b0, a, 8'h00, q);
    cmp($sformatf("reg %h", a), e, q);
  endtask : rd

  // Main sequence
  initial begin
    rst_n = 1'b0;
    hp_pin = 1'b0;
    grp = 6'h00;
    repeat (2) @(posedge ref_clk);
    rst_n <= 1'b1;
    @(negedge ref_clk);
    cmp("ctl1 outputs", {dc, hu, ad, ss, d44, d48}, 6'h3c);
    cmp("format", {fres, s32, frame, len}, 9'h038);
    cmp("run", {run, valid, hpvol}, 8'h01);
    rd(8'h0c, 8'ha0);
    rd(8'h10, 8'h05);
    rd(8'h14, 8'h60);
    // Status after reset: only the latched all-channel bit is set
    rd(8'h80, 8'h40);
    wr(8'h18, 8'hff);
    rd(8'h18, 8'h00);
    for (int i = 0; i < 4; i++) begin
      wr(8'h0c, 8'h4c | 8'(i));
      rd(8'h0c, 8'h4c | 8'(i));
      cmp("ctl1 outputs", {dc, hu, ad, ss, d44, d48}, {4'h0, i == 2, i == 3});
    end
    for (int i = 0; i < 14; i++) begin
      wr(8'h10, fc[i]);
      rd(8'h10, fc[i]);
      cmp("format", {fres, s32, frame, len}, fx[i]);
    end
    @(posedge ref_clk);
    grp <= 6'h05;
    wr(8'h14, 8'h20);
    cmp("run", {run, valid}, {6'h3f, 1'b1});
    // Status while running all channels: config, any running, valid
    rd(8'h80, 8'h43);
    wr(8'h14, 8'h60);
    cmp("run", {run, valid}, 7'h00);
    wr(8'h14, 8'h40);
    wr(8'h14, 8'h00);
    cmp("run", {run, valid}, {6'h3a, 1'b0});
    @(posedge ref_clk);
    grp <= 6'h3c;
    @(negedge ref_clk);
    @(negedge ref_clk);
    cmp("run", run, 6'h03);
    // Shut down first, so the loop sets the all-channel bit only while stopped
    wr(8'h14, 8'h40);
    for (int m = 0; m < 4; m++) begin
      for (int p = 0; p < 2; p++) begin
        @(posedge ref_clk);
        hp_pin <= p[0];
        wr(8'h14, 8'h60 | (m == 2 ? 8'h08 : 8'h00) | 8'(m << 1));
        hpm = m != 2 && (m == 1 || p == 1);
        cmp("mode", {hp, line, mute, hpen, hpvol}, {hpm, m == 2, hpm, hpm || m == 2, m != 2});
      end
    end
    // Reset again while shut down: registers and decoded outputs return to their reset state
    @(posedge ref_clk);
    rst_n <= 1'b0;
    repeat (2) @(posedge ref_clk);
    rst_n <= 1'b1;
    @(negedge ref_clk);
    cmp("ctl1 outputs", {dc, hu, ad, ss, d44, d48}, 6'h3c);
    cmp("run", {run, valid, hpvol}, 8'h01);
    rd(8'h14, 8'h60);
    rd(8'h0c, 8'ha0);
    conclude();
  end
endmodule : testbench
`default_nettype wire

// [verilog/asc_pkg.sv]
// Register map, field layout and reset values of the amplifier system control bank
`default_nettype none
package asc_pkg;

  // Register indices; byte address is four times the index
  localparam logic [5:0] IDX_SYS_CTRL_ONE  = 6'h03;
  localparam logic [5:0] IDX_SERIAL_FORMAT = 6'h04;
  localparam logic [5:0] IDX_SYS_CTRL_TWO  = 6'h05;
  localparam logic [5:0] IDX_STATUS        = 6'h20;

  // Reset values
  localparam logic [7:0] RST_SYS_CTRL_ONE  = 8'ha0;
  localparam logic [7:0] RST_SERIAL_FORMAT = 8'h05;
  localparam logic [7:0] RST_SYS_CTRL_TWO  = 8'h60;

  // System control one fields
  localparam int unsigned S1_DC_BLOCK    = 7;
  localparam int unsigned S1_HARD_UNMUTE = 5;
  localparam int unsigned S1_AUTODET_OFF = 3;
  localparam int unsigned S1_SOFTST_OFF  = 2;
  localparam int unsigned S1_DEEMPH_HI   = 1;
  localparam int unsigned S1_DEEMPH_LO   = 0;

  // De-emphasis codes
  localparam logic [1:0] DEEMPH_NONE = 2'h0;
  localparam logic [1:0] DEEMPH_441K = 2'h2;
  localparam logic [1:0] DEEMPH_48K  = 2'h3;

  // System control two fields
  localparam int unsigned S2_SHUTDOWN   = 6;
  localparam int unsigned S2_ALL_CH     = 5;
  localparam int unsigned S2_VOL_SRC    = 3;
  localparam int unsigned S2_MODE_HI    = 2;
  localparam int unsigned S2_MODE_LO    = 1;

  // Output mode codes
  localparam logic [1:0] MODE_SPEAKER  = 2'h0;
  localparam logic [1:0] MODE_HEADPH   = 2'h1;
  localparam logic [1:0] MODE_LINE_OUT = 2'h2;

  // Serial format codes (low five bits, upper three zero)
  localparam logic [7:0] FMT_RJ16     = 8'h00;
  localparam logic [7:0] FMT_RJ20     = 8'h01;
  localparam logic [7:0] FMT_RJ24     = 8'h02;
  localparam logic [7:0] FMT_I2S16    = 8'h03;
  localparam logic [7:0] FMT_I2S20    = 8'h04;
  localparam logic [7:0] FMT_I2S24    = 8'h05;
  localparam logic [7:0] FMT_LJ16     = 8'h06;
  localparam logic [7:0] FMT_LJ20     = 8'h07;
  localparam logic [7:0] FMT_LJ24     = 8'h08;
  localparam logic [7:0] FMT_RJ18     = 8'h0a;
  localparam logic [7:0] FMT_I2S16_32 = 8'h13;
  localparam logic [7:0] FMT_LJ_32    = 8'h16;

  // Word lengths
  localparam logic [4:0] WL_16 = 5'h10;
  localparam logic [4:0] WL_18 = 5'h12;
  localparam logic [4:0] WL_20 = 5'h14;
  localparam logic [4:0] WL_24 = 5'h18;

  // Framing kinds
  typedef enum logic [1:0] {
    ASC_FRAME_RJ,
    ASC_FRAME_I2S,
    ASC_FRAME_LJ
  } asc_frame_t;

  // Status register bit positions
  localparam int unsigned ST_VALID    = 0;
  localparam int unsigned ST_RUNNING  = 1;
  localparam int unsigned ST_HP_MODE  = 2;
  localparam int unsigned ST_LINE_OUT = 3;
  localparam int unsigned ST_PIN      = 4;
  localparam int unsigned ST_FMT_BAD  = 5;
  localparam int unsigned ST_ALL_CH   = 6;

endpackage : asc_pkg
`default_nettype wire

// [verilog/asc_regs.sv]
// System control register bank of the audio amplifier, classic Wishbone slave
//
// Functional notes
// - System control one D7 set enables dc-blocking filter; reset value one.
// - D5 zero unmutes softly after clock error; one (reset) unmutes at once.
// - D3 zero (reset) keeps clock autodetect on; one turns it off.
// - D2 zero (reset) enables soft start; one skips it.
// - De-emphasis: 00 none, 01 reserved, 10 for 44.1 kHz, 11 for 48 kHz.
// - Serial format low five bits pick framing and word length; others reserved.
// - Serial format resets to I2S with 24-bit words, code 00101.
// - System control two D6 high shuts all channels; low runs outputs.
// - D5, latched only while D6 is high, set starts every channel; clear starts only those outside shutdown group.
// - Output-valid low while shut down; high once all channels run all-channel.
// - D3 zero uses headphone volume register in headphone mode; one uses channel volumes.
// - Mode 00 speaker with pin forcing headphone, 01 headphone ORed pin, 10 line-out.
// - Headphone mode mutes every PWM channel except the headphone outputs.
`default_nettype none
module asc_regs #(
  parameter int unsigned NUM_CH = 6
) (
  // Clock and reset
  input  wire  logic              ref_clk,
  input  wire  logic              rst_n,
  // Wishbone slave
  input  wire  logic              wb_cyc_i,
  input  wire  logic              wb_stb_i,
  input  wire  logic              wb_we_i,
  input  wire  logic [7:0]        wb_adr_i,
  input  wire  logic [3:0]        wb_sel_i,
  input  wire  logic [31:0]       wb_dat_i,
  output logic [31:0]             wb_dat_o,
  output logic                    wb_ack_o,
  // Pin and neighbouring register inputs
  input  wire  logic              headphone_select_pin,
  input  wire  logic [NUM_CH-1:0] shutdown_group,
  // Filter and recovery controls
  output logic                    dc_block_en_r,
  output logic                    hard_unmute_r,
  output logic                    clk_autodetect_en_r,
  output logic                    soft_start_en_r,
  output logic                    deemph_44k_r,
  output logic                    deemph_48k_r,
  // Serial audio receiver setup
  output asc_pkg::asc_frame_t     frame_kind_r,
  output logic [4:0]              word_len_r,
  output logic                    sclk_32fs_r,
  output logic                    fmt_reserved_r,
  // Output stage controls
  output logic [NUM_CH-1:0]       channel_run_r,
  output logic                    outputs_valid_flag_r,
  output logic                    speaker_mute_r,
  output logic                    headphone_pwm_outputs_en_r,
  output logic                    hp_mode_r,
  output logic                    line_out_mode_r,
  output logic                    hp_vol_from_hp_reg_r
);

  // Stored registers
  logic [7:0] sys_ctrl_one_r;
  logic [7:0] serial_format_r;
  logic [7:0] sys_ctrl_two_r;
  logic       all_ch_cfg_r;
  logic [7:0] sys_ctrl_one_nxt;
  logic [7:0] serial_format_nxt;
  logic [7:0] sys_ctrl_two_nxt;

  // Synchronised headphone select pin
  logic hp_pin_sync;

  // Pin comes from outside the clock domain, so two flops stand before any logic
  asc_sync u_hp_sync (
    .ref_clk  (ref_clk),
    .rst_n    (rst_n),
    .async_in (headphone_select_pin),
    .sync_out (hp_pin_sync)
  );

  // Merge one byte lane into a stored byte
  function automatic logic [7:0] merge_byte(input logic [7:0] old_v, input logic [7:0] new_v,
                                            input logic lane_en);
    merge_byte = lane_en ? new_v : old_v;
  endfunction : merge_byte

  // Two-bit field at a given position; the de-emphasis and output mode decodes share it
  function automatic logic [1:0] field_pair(input logic [7:0] reg_v, input int unsigned lo_pos);
    field_pair = reg_v[lo_pos +: 2];
  endfunction : field_pair

  // Bus decode
  wire        req       = wb_cyc_i & wb_stb_i & ~wb_ack_o;
  wire [5:0]  idx       = wb_adr_i[7:2];
  // Only byte lane 0 carries a register; writes on other lanes change nothing
  wire        wr_lane   = req & wb_we_i & wb_sel_i[0];
  wire        hit_one   = (idx == asc_pkg::IDX_SYS_CTRL_ONE);
  wire        hit_fmt   = (idx == asc_pkg::IDX_SERIAL_FORMAT);
  wire        hit_two   = (idx == asc_pkg::IDX_SYS_CTRL_TWO);
  wire        hit_stat  = (idx == asc_pkg::IDX_STATUS);

  // Reserved bits are stored like any other bit; only the serial format upper bits are decoded, as reserved codes
  assign sys_ctrl_one_nxt  = merge_byte(sys_ctrl_one_r, wb_dat_i[7:0], wr_lane & hit_one);
  assign serial_format_nxt = merge_byte(serial_format_r, wb_dat_i[7:0], wr_lane & hit_fmt);
  assign sys_ctrl_two_nxt  = merge_byte(sys_ctrl_two_r, wb_dat_i[7:0], wr_lane & hit_two);

  // Status word shows the block's live state
  wire [7:0] status_word = {1'b0,
                            all_ch_cfg_r,
                            fmt_reserved_r,
                            hp_pin_sync,
                            line_out_mode_r,
                            hp_mode_r,
                            |channel_run_r,
                            outputs_valid_flag_r};

  // Read mux; unmapped addresses read zero
  // Status is read-only: a write to its index changes nothing
  wire [7:0] rd_byte = hit_one  ? sys_ctrl_one_r  :
                       hit_fmt  ? serial_format_r :
                       hit_two  ? sys_ctrl_two_r  :
                       hit_stat ? status_word     : 8'h00;

  // Bus answer: ack one cycle after the request, every address answered
  // Ack lasts one cycle; a strobe still held after it is taken again, so masters release on ack
  always_ff @(posedge ref_clk or negedge rst_n) begin
    if (!rst_n) begin
      wb_ack_o <= 1'b0;
      wb_dat_o <= 32'h0000_0000;
    end else begin
      wb_ack_o <= req;
      wb_dat_o <= req ? {24'h00_0000, rd_byte} : 32'h0000_0000;
    end
  end

  // Register storage with documented reset values
  // A write lands on the edge that takes the request, the same edge that raises the ack
  always_ff @(posedge ref_clk or negedge rst_n) begin
    if (!rst_n) begin
      sys_ctrl_one_r  <= asc_pkg::RST_SYS_CTRL_ONE;
      serial_format_r <= asc_pkg::RST_SERIAL_FORMAT;
      sys_ctrl_two_r  <= asc_pkg::RST_SYS_CTRL_TWO;
    end else begin
      sys_ctrl_one_r  <= sys_ctrl_one_nxt;
      serial_format_r <= serial_format_nxt;
      sys_ctrl_two_r  <= sys_ctrl_two_nxt;
    end
  end

  // System control one decode
  wire [1:0] deemph_code = field_pair(sys_ctrl_one_r, asc_pkg::S1_DEEMPH_LO);

  always_ff @(posedge ref_clk or negedge rst_n) begin
    if (!rst_n) begin
      // Same values the register reset decodes to, so nothing moves at release
      dc_block_en_r       <= asc_pkg::RST_SYS_CTRL_ONE[asc_pkg::S1_DC_BLOCK];
      hard_unmute_r       <= asc_pkg::RST_SYS_CTRL_ONE[asc_pkg::S1_HARD_UNMUTE];
      clk_autodetect_en_r <= ~asc_pkg::RST_SYS_CTRL_ONE[asc_pkg::S1_AUTODET_OFF];
      soft_start_en_r     <= ~asc_pkg::RST_SYS_CTRL_ONE[asc_pkg::S1_SOFTST_OFF];
      deemph_44k_r        <= 1'b0;
      deemph_48k_r        <= 1'b0;
    end else begin
      dc_block_en_r       <= sys_ctrl_one_r[asc_pkg::S1_DC_BLOCK];
      hard_unmute_r       <= sys_ctrl_one_r[asc_pkg::S1_HARD_UNMUTE];
      clk_autodetect_en_r <= ~sys_ctrl_one_r[asc_pkg::S1_AUTODET_OFF];
      soft_start_en_r     <= ~sys_ctrl_one_r[asc_pkg::S1_SOFTST_OFF];
      // Reserved code 01 behaves as no de-emphasis
      deemph_44k_r        <= (deemph_code == asc_pkg::DEEMPH_441K);
      deemph_48k_r        <= (deemph_code == asc_pkg::DEEMPH_48K);
    end
  end

  // Serial format decode; reserved codes keep the last good setup
  asc_pkg::asc_frame_t fmt_kind;
  logic [4:0]          fmt_len;
  logic                fmt_32;
  logic                fmt_ok;

  always_comb begin
    fmt_kind = asc_pkg::ASC_FRAME_I2S;
    fmt_len  = asc_pkg::WL_24;
    fmt_32   = 1'b0;
    fmt_ok   = 1'b1;
    case (serial_format_r)
      asc_pkg::FMT_RJ16: begin
        fmt_kind = asc_pkg::ASC_FRAME_RJ;
        fmt_len  = asc_pkg::WL_16;
      end
      asc_pkg::FMT_RJ20: begin
        fmt_kind = asc_pkg::ASC_FRAME_RJ;
        fmt_len  = asc_pkg::WL_20;
      end
      asc_pkg::FMT_RJ24: begin
        fmt_kind = asc_pkg::ASC_FRAME_RJ;
      end
      asc_pkg::FMT_I2S16: begin
        fmt_len  = asc_pkg::WL_16;
      end
      asc_pkg::FMT_I2S20: begin
        fmt_len  = asc_pkg::WL_20;
      end
      asc_pkg::FMT_I2S24: begin
        fmt_len  = asc_pkg::WL_24;
      end
      asc_pkg::FMT_LJ16: begin
        fmt_kind = asc_pkg::ASC_FRAME_LJ;
        fmt_len  = asc_pkg::WL_16;
      end
      asc_pkg::FMT_LJ20: begin
        fmt_kind = asc_pkg::ASC_FRAME_LJ;
        fmt_len  = asc_pkg::WL_20;
      end
      asc_pkg::FMT_LJ24: begin
        fmt_kind = asc_pkg::ASC_FRAME_LJ;
      end
      asc_pkg::FMT_RJ18: begin
        fmt_kind = asc_pkg::ASC_FRAME_RJ;
        fmt_len  = asc_pkg::WL_18;
      end
      asc_pkg::FMT_I2S16_32: begin
        fmt_len  = asc_pkg::WL_16;
        fmt_32   = 1'b1;
      end
      asc_pkg::FMT_LJ_32: begin
        // Word length not given for this code; 16 fits a 32x bit clock
        fmt_kind = asc_pkg::ASC_FRAME_LJ;
        fmt_len  = asc_pkg::WL_16;
        fmt_32   = 1'b1;
      end
      default: begin
        // Unlisted low codes and any upper bit set are reserved
        fmt_ok   = 1'b0;
      end
    endcase
  end

  // Receiver setup registers, reset to I2S 24-bit
  always_ff @(posedge ref_clk or negedge rst_n) begin
    if (!rst_n) begin
      frame_kind_r   <= asc_pkg::ASC_FRAME_I2S;
      word_len_r     <= asc_pkg::WL_24;
      sclk_32fs_r    <= 1'b0;
      fmt_reserved_r <= 1'b0;
    end else begin
      // Flag follows every cycle so software sees a bad code at once
      fmt_reserved_r <= ~fmt_ok;
      if (fmt_ok) begin
        frame_kind_r <= fmt_kind;
        word_len_r   <= fmt_len;
        sclk_32fs_r  <= fmt_32;
      end
    end
  end

  // System control two decode
  wire       shutdown   = sys_ctrl_two_r[asc_pkg::S2_SHUTDOWN];
  wire       vol_src    = sys_ctrl_two_r[asc_pkg::S2_VOL_SRC];
  wire [1:0] mode_code  = field_pair(sys_ctrl_two_r, asc_pkg::S2_MODE_LO);
  // Reserved mode 11 is treated as speaker mode
  wire       line_out   = (mode_code == asc_pkg::MODE_LINE_OUT);
  wire       hp_forced  = (mode_code == asc_pkg::MODE_HEADPH);
  // The pin passes the synchroniser first, so it reaches hp_mode_r three edges after it moves
  wire       hp_mode    = ~line_out & (hp_forced | hp_pin_sync);

  // Configuration is taken only while shut down, so a stray change during play has no effect
  always_ff @(posedge ref_clk or negedge rst_n) begin
    if (!rst_n) begin
      // Matches the all-channel bit of the register reset value
      all_ch_cfg_r <= asc_pkg::RST_SYS_CTRL_TWO[asc_pkg::S2_ALL_CH];
    end else if (shutdown) begin
      all_ch_cfg_r <= sys_ctrl_two_r[asc_pkg::S2_ALL_CH];
    end
  end

  // Channel start: all channels, or only those outside the shutdown group
  wire [NUM_CH-1:0] run_set = shutdown     ? '0 :
                              all_ch_cfg_r ? '1 : ~shutdown_group;

  // Output stage controls
  always_ff @(posedge ref_clk or negedge rst_n) begin
    if (!rst_n) begin
      channel_run_r              <= '0;
      outputs_valid_flag_r       <= 1'b0;
      speaker_mute_r             <= 1'b0;
      headphone_pwm_outputs_en_r <= 1'b0;
      hp_mode_r                  <= 1'b0;
      line_out_mode_r            <= 1'b0;
      hp_vol_from_hp_reg_r       <= ~asc_pkg::RST_SYS_CTRL_TWO[asc_pkg::S2_VOL_SRC];
    end else begin
      channel_run_r              <= run_set;
      // Valid follows the channels one cycle later, once they really run
      outputs_valid_flag_r       <= ~shutdown & all_ch_cfg_r & (&channel_run_r);
      // Speakers mute whenever headphones are selected, by register or by pin
      speaker_mute_r             <= hp_mode;
      headphone_pwm_outputs_en_r <= hp_mode | line_out;
      hp_mode_r                  <= hp_mode;
      line_out_mode_r            <= line_out;
      // Line-out expects the host to select channel volumes
      hp_vol_from_hp_reg_r       <= ~vol_src;
    end
  end

endmodule : asc_regs
`default_nettype wire

// [verilog/asc_sync.sv]
// Two-flop synchroniser for an asynchronous level input
`default_nettype none
module asc_sync (
  // Clock and reset
  input  wire  logic ref_clk,
  input  wire  logic rst_n,
  // Level in and out
  input  wire  logic async_in,
  output logic       sync_out
);

  logic meta_r;

  // First flop feeds only the second one
  always_ff @(posedge ref_clk or negedge rst_n) begin
    if (!rst_n) begin
      meta_r   <= 1'b0;
      sync_out <= 1'b0;
    end else begin
      meta_r   <= async_in;
      sync_out <= meta_r;
    end
  end

endmodule : asc_sync
`default_nettype wire
